// File: core/gpab_consts.svh
`ifndef GPAB_CONSTS_SVH
`define GPAB_CONSTS_SVH

// Register word indices (byte address = index * 4)
`define GPAB_IDX_PORT_A_LATCH 4'h0
`define GPAB_IDX_PORT_B_LATCH 4'h1
`define GPAB_IDX_PORT_A_DIRECTION 4'h4
`define GPAB_IDX_PORT_B_DIRECTION 4'h5
`define GPAB_IDX_PORT_A_LED_ENABLE 4'hC

// Reset values
`define GPAB_DIRECTION_RESET 8'h00
`define GPAB_LED_ENABLE_RESET 8'h00

// Bus response codes
`define GPAB_RESP_OKAY 2'h0
`define GPAB_RESP_ERROR 2'h2

// Port B pin positions
`define GPAB_PB_I2C_DATA 0
`define GPAB_PB_I2C_CLOCK 1
`define GPAB_PB_SERIAL_TX 2
`define GPAB_PB_SERIAL_RX 3
`define GPAB_PB_OPEN_DRAIN_MASK 8'h0F

// Converter channel-select codes 0..7 pick port A pins
`define GPAB_CHANNEL_PORT_A_LAST 5'h07

`endif

// File: core/gpab_pkg.sv
package gpab_pkg;

	typedef enum logic [1:0] {
		GPAB_BUS_IDLE,
		GPAB_BUS_ANSWER
	} gpab_bus_state_t;

endpackage : gpab_pkg

// File: core/gpab_ports.sv
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "gpab_consts.svh"

module gpab_ports import gpab_pkg::*; #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Avalon-MM slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	// Port A pins
	input wire logic [WIDTH-1:0] port_a_pin_in,
	output logic [WIDTH-1:0] port_a_pin_out,
	output logic [WIDTH-1:0] port_a_pin_oe,
	output logic [WIDTH-1:0] port_a_led_drive,
	output logic [WIDTH-1:0] port_a_analog_select,
	// Converter
	input wire logic converter_enable,
	input wire logic [4:0] converter_channel_select,
	// Port B pins
	input wire logic [WIDTH-1:0] port_b_pin_in,
	output logic [WIDTH-1:0] port_b_pin_out,
	output logic [WIDTH-1:0] port_b_pin_oe,
	// Peripheral enables
	input wire logic i2c_module_enable,
	input wire logic serial_interface_enable,
	// Timer edge/level selects
	input wire logic [1:0] first_timer_ch0_select,
	input wire logic [1:0] first_timer_ch1_select,
	input wire logic [1:0] second_timer_ch0_select,
	input wire logic [1:0] second_timer_ch1_select,
	// Peripheral pin drive
	input wire logic i2c_data_oe,
	input wire logic i2c_clock_oe,
	input wire logic serial_tx_out,
	input wire logic serial_tx_oe,
	// Timer pin drive
	input wire logic [3:0] timer_pin_out,
	input wire logic [3:0] timer_pin_oe
);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] port_a_latch;
	logic [WIDTH-1:0] port_a_direction;
	logic [WIDTH-1:0] port_a_led_enable;
	logic [WIDTH-1:0] port_b_latch;
	logic [WIDTH-1:0] port_b_direction;
	gpab_bus_state_t bus_state;
	gpab_bus_state_t next_bus_state;

	// Read mux: latch where output, pin where input
	function automatic logic [WIDTH-1:0] port_read(input logic [WIDTH-1:0] dir,
			input logic [WIDTH-1:0] latch, input logic [WIDTH-1:0] pin);
		port_read = (dir & latch) | (~dir & pin);
	endfunction : port_read

	// Owner select, bit by bit: the peripheral's bit where it owns the pin
	function automatic logic [WIDTH-1:0] owner_pick(input logic [WIDTH-1:0] owns,
			input logic [WIDTH-1:0] periph, input logic [WIDTH-1:0] port);
		owner_pick = (owns & periph) | (~owns & port);
	endfunction : owner_pick

	// Any edge/level setting but 00 hands the pin to its timer channel
	function automatic logic timer_claims(input logic [1:0] sel);
		timer_claims = (sel != 2'h0);
	endfunction : timer_claims

	// Only aligned words decode; a byte offset inside a word is unmapped
	function automatic logic word_hit(input logic [5:0] addr, input logic [3:0] idx);
		word_hit = (addr[1:0] == 2'h0) && (addr[5:2] == idx);
	endfunction : word_hit

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire logic hit_a_latch = word_hit(avs_address, `GPAB_IDX_PORT_A_LATCH);
	wire logic hit_b_latch = word_hit(avs_address, `GPAB_IDX_PORT_B_LATCH);
	wire logic hit_a_dir = word_hit(avs_address, `GPAB_IDX_PORT_A_DIRECTION);
	wire logic hit_b_dir = word_hit(avs_address, `GPAB_IDX_PORT_B_DIRECTION);
	wire logic hit_a_led = word_hit(avs_address, `GPAB_IDX_PORT_A_LED_ENABLE);
	wire logic hit_any = hit_a_latch | hit_b_latch | hit_a_dir | hit_b_dir | hit_a_led;
	wire logic bus_request = avs_read | avs_write;
	wire logic bus_idle = (bus_state == GPAB_BUS_IDLE);
	// A request is taken only from idle, so a held request is not taken twice
	wire logic req = bus_request && bus_idle;
	// Only byte lane 0 carries register data; other lanes are ignored
	wire logic wr_go = req && avs_write && avs_byteenable[0];
	wire logic [WIDTH-1:0] wdata = avs_writedata[WIDTH-1:0];

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// An output pin reads its latch, not its level: software sees what it
	// wrote even when a heavy load drags the pin.
	wire logic [WIDTH-1:0] read_a = port_read(port_a_direction, port_a_latch, port_a_pin_in);
	wire logic [WIDTH-1:0] read_b = port_read(port_b_direction, port_b_latch, port_b_pin_in);
	wire logic [WIDTH-1:0] read_sel =
		hit_a_latch ? read_a :
		hit_b_latch ? read_b :
		hit_a_dir ? port_a_direction :
		hit_b_dir ? port_b_direction :
		hit_a_led ? port_a_led_enable : '0;
	wire logic [31:0] read_word = {{(32-WIDTH){1'b0}}, read_sel};
	// Writes answer with zero data rather than a stale read
	wire logic [31:0] next_avs_readdata = avs_read ? read_word : 32'h0000_0000;
	wire logic [1:0] next_avs_response = hit_any ? `GPAB_RESP_OKAY : `GPAB_RESP_ERROR;
	// Waitrequest drops only for the cycle after a request is taken
	wire logic next_avs_waitrequest = ~req;

	// ----------------------------------------------------------------
	// Bus handshake: one wait cycle, answer on the second edge
	// ----------------------------------------------------------------
	// The answer is registered so no pin level ripples straight onto the bus;
	// the price is one wait cycle on every access.
	always_comb begin
		next_bus_state = bus_state;
		unique case (bus_state)
			GPAB_BUS_IDLE: begin
				if (bus_request) begin
					next_bus_state = GPAB_BUS_ANSWER;
				end
			end
			GPAB_BUS_ANSWER: begin
				next_bus_state = GPAB_BUS_IDLE;
			end
			default: begin
				next_bus_state = GPAB_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bus_state <= GPAB_BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
			avs_response <= `GPAB_RESP_OKAY;
		end else begin
			bus_state <= next_bus_state;
			avs_waitrequest <= next_avs_waitrequest;
			if (req) begin
				avs_readdata <= next_avs_readdata;
				avs_response <= next_avs_response;
			end
		end
	end

	// ----------------------------------------------------------------
	// Write strobes
	// ----------------------------------------------------------------
	// Each strobe lasts one cycle: a request is taken once, from idle
	wire logic wr_a_latch = wr_go && hit_a_latch;
	wire logic wr_b_latch = wr_go && hit_b_latch;
	wire logic wr_a_dir = wr_go && hit_a_dir;
	wire logic wr_b_dir = wr_go && hit_b_dir;
	wire logic wr_a_led = wr_go && hit_a_led;

	// ----------------------------------------------------------------
	// Control registers with reset
	// ----------------------------------------------------------------
	// Everything comes up as an input with standard drive, so nothing is
	// driven before software has chosen a level.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			port_a_direction <= `GPAB_DIRECTION_RESET;
			port_b_direction <= `GPAB_DIRECTION_RESET;
			port_a_led_enable <= `GPAB_LED_ENABLE_RESET;
		end else begin
			if (wr_a_dir) begin
				port_a_direction <= wdata;
			end
			if (wr_b_dir) begin
				port_b_direction <= wdata;
			end
			if (wr_a_led) begin
				port_a_led_enable <= wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Data latches: no reset, written regardless of direction
	// ----------------------------------------------------------------
	// Power-up content is unknown until software loads it first. Leaving
	// reset out lets a preloaded level survive a reset pulse.
	always_ff @(posedge clk) begin
		if (wr_a_latch) begin
			port_a_latch <= wdata;
		end
		if (wr_b_latch) begin
			port_b_latch <= wdata;
		end
	end

	// ----------------------------------------------------------------
	// Port A analog override
	// ----------------------------------------------------------------
	// Codes 0..7 name one port A pin; higher codes name other channels and
	// leave every port A pin to the port logic.
	wire logic channel_on_port_a = converter_enable &&
		(converter_channel_select <= `GPAB_CHANNEL_PORT_A_LAST);
	wire logic [2:0] channel_pin = converter_channel_select[2:0];
	logic [WIDTH-1:0] analog_pick;
	always_comb begin
		analog_pick = '0;
		if (channel_on_port_a) begin
			analog_pick[channel_pin] = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Port A drive
	// ----------------------------------------------------------------
	// The analog pin loses its buffer whatever its direction bit says, so a
	// digital output never fights the voltage being converted.
	wire logic [WIDTH-1:0] next_a_oe = port_a_direction & ~analog_pick;
	// High-current sink only on a pin that drives; an input pin with its
	// enable bit set stays on standard drive.
	wire logic [WIDTH-1:0] next_a_led = port_a_led_enable & next_a_oe;
	wire logic [WIDTH-1:0] next_a_out = port_a_latch;
	wire logic [WIDTH-1:0] next_a_analog = analog_pick;

	// ----------------------------------------------------------------
	// Port B ownership
	// ----------------------------------------------------------------
	// Pins 1..0 follow the I2C enable, pins 3..2 the serial enable and
	// pins 7..4 one timer channel each.
	wire logic i2c_owns = i2c_module_enable;
	wire logic serial_owns = serial_interface_enable;
	wire logic timer_one_ch0_owns = timer_claims(first_timer_ch0_select);
	wire logic timer_one_ch1_owns = timer_claims(first_timer_ch1_select);
	wire logic timer_two_ch0_owns = timer_claims(second_timer_ch0_select);
	wire logic timer_two_ch1_owns = timer_claims(second_timer_ch1_select);
	wire logic [3:0] timer_owns = {timer_two_ch1_owns, timer_two_ch0_owns,
		timer_one_ch1_owns, timer_one_ch0_owns};
	wire logic [WIDTH-1:0] periph_owns = {timer_owns, serial_owns, serial_owns,
		i2c_owns, i2c_owns};

	// ----------------------------------------------------------------
	// Peripheral drive per pin
	// ----------------------------------------------------------------
	// I2C lines only ever pull low, so their value is a constant zero
	wire logic [1:0] i2c_oe = {i2c_clock_oe, i2c_data_oe};
	wire logic [1:0] i2c_out = 2'h0;
	// Receive is input-only for the serial module; only transmit drives
	wire logic [1:0] serial_oe = {1'b0, serial_tx_oe};
	wire logic [1:0] serial_out = {1'b0, serial_tx_out};
	wire logic [WIDTH-1:0] periph_oe = {timer_pin_oe, serial_oe, i2c_oe};
	wire logic [WIDTH-1:0] periph_out = {timer_pin_out, serial_out, i2c_out};

	// ----------------------------------------------------------------
	// Port B pin control
	// ----------------------------------------------------------------
	// The registers still read and write while a peripheral owns a pin;
	// they only stop reaching it until ownership returns.
	wire logic [WIDTH-1:0] mux_oe =
		owner_pick(periph_owns, periph_oe, port_b_direction);
	wire logic [WIDTH-1:0] mux_out =
		owner_pick(periph_owns, periph_out, port_b_latch);

	// ----------------------------------------------------------------
	// Open drain on the lower nibble
	// ----------------------------------------------------------------
	// These pins only sink; a released line floats up to its board pull-up,
	// so a one never fights another driver on a shared line.
	wire logic [WIDTH-1:0] od_mask = `GPAB_PB_OPEN_DRAIN_MASK;
	wire logic [WIDTH-1:0] push_pull = mux_oe & ~od_mask;
	wire logic [WIDTH-1:0] od_low = mux_oe & ~mux_out & od_mask;
	wire logic [WIDTH-1:0] next_b_oe = push_pull | od_low;
	wire logic [WIDTH-1:0] next_b_out = mux_out & ~od_mask;

	// ----------------------------------------------------------------
	// Port A registered outputs
	// ----------------------------------------------------------------
	// One cycle behind control changes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			port_a_pin_oe <= '0;
			port_a_pin_out <= '0;
			port_a_led_drive <= '0;
			port_a_analog_select <= '0;
		end else begin
			port_a_pin_oe <= next_a_oe;
			port_a_pin_out <= next_a_out;
			port_a_led_drive <= next_a_led;
			port_a_analog_select <= next_a_analog;
		end
	end

	// ----------------------------------------------------------------
	// Port B registered outputs
	// ----------------------------------------------------------------
	// Reset releases every pin, peripheral-owned ones included
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			port_b_pin_oe <= '0;
			port_b_pin_out <= '0;
		end else begin
			port_b_pin_oe <= next_b_oe;
			port_b_pin_out <= next_b_out;
		end
	end

endmodule : gpab_ports

// File: sim/gpab_ports_asserts.sv
`timescale 1ns/1ps
module gpab_ports_asserts #(parameter int WIDTH = 8) (
	// Clock, reset and handshake
	input wire logic clk,
	input wire logic nrst,
	input wire logic avs_read,
	input wire logic avs_waitrequest,
	// Pins
	input wire logic [WIDTH-1:0] port_a_pin_oe,
	input wire logic [WIDTH-1:0] port_a_analog_select,
	input wire logic [WIDTH-1:0] port_b_pin_out,
	input wire logic [WIDTH-1:0] port_b_pin_oe,
	// Controls
	input wire logic converter_enable,
	input wire logic [4:0] converter_channel_select,
	input wire logic i2c_module_enable,
	input wire logic i2c_data_oe,
	input wire logic serial_interface_enable,
	input wire logic serial_tx_out,
	input wire logic serial_tx_oe,
	input wire logic [1:0] first_timer_ch0_select,
	input wire logic [3:0] timer_pin_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	reset_idle_a: assert property ($rose(nrst) |-> avs_waitrequest && port_a_pin_oe == 8'h00
		&& port_b_pin_oe == 8'h00) else $error("outputs not idle after reset");
	read_answer_a: assert property ($rose(avs_read) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("read not answered in one cycle");
	analog_pick_a: assert property ((converter_enable && converter_channel_select < 5'h08)
		|=> port_a_analog_select == (8'h01 << $past(converter_channel_select[2:0])))
		else $error("wrong analog pin");
	analog_free_a: assert property ((port_a_pin_oe & port_a_analog_select) == 8'h00)
		else $error("analog pin still driven");
	open_drain_a: assert property ((port_b_pin_oe[3:0] & port_b_pin_out[3:0]) == 4'h0)
		else $error("lower port B pin driven high");
	i2c_data_a: assert property (i2c_module_enable |=> port_b_pin_oe[0] == $past(i2c_data_oe))
		else $error("data pin not owned by i2c");
	serial_pins_a: assert property (serial_interface_enable |=> !port_b_pin_oe[3]
		&& port_b_pin_oe[2] == ($past(serial_tx_oe) && !$past(serial_tx_out)))
		else $error("serial pins not owned");
	timer_pin_a: assert property (first_timer_ch0_select != 2'b00
		|=> port_b_pin_oe[4] == $past(timer_pin_oe[0])) else $error("timer pin not owned");
	cover property (i2c_module_enable && serial_interface_enable);
	cover property (converter_enable);
	cover property (!avs_waitrequest);
endmodule : gpab_ports_asserts
bind gpab_ports gpab_ports_asserts #(.WIDTH(WIDTH)) gpab_ports_asserts_i (.*);

// File: sim/gpab_pins.sv
`timescale 1ns/1ps
module gpab_pins (
	// Block drive and board levels
	input wire logic [7:0] a_out, a_oe, b_out, b_oe, a_board, b_board,
	// Resolved levels
	output logic [7:0] a_in, b_in
);
	// Lower port B nibble has pull-ups, so a released open-drain line reads high
	assign a_in = (a_oe & a_out) | (~a_oe & a_board);
	assign b_in = (b_oe & b_out) | (~b_oe & {b_board[7:4], 4'hF});
endmodule : gpab_pins

// File: sim/test_gpab_ports.sv
`timescale 1ns/1ps
module test_gpab_ports;
	logic clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [5:0] avs_address = 6'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [3:0] avs_byteenable = 4'hF, timer_pin_out = 4'h8, timer_pin_oe = 4'h9;
	logic [1:0] avs_response, r, first_timer_ch0_select = 2'h0, second_timer_ch1_select = 2'h0;
	logic [1:0] first_timer_ch1_select = 2'h0, second_timer_ch0_select = 2'h0;
	logic [7:0] port_a_pin_in, port_a_pin_out, port_a_pin_oe, port_a_led_drive;
	logic [7:0] port_a_analog_select, port_b_pin_in, port_b_pin_out, port_b_pin_oe;
	logic converter_enable = 1'b0, i2c_module_enable = 1'b0, i2c_data_oe = 1'b0;
	logic i2c_clock_oe = 1'b1, serial_interface_enable = 1'b0, serial_tx_out = 1'b0;
	logic serial_tx_oe = 1'b1;
	logic [4:0] converter_channel_select = 5'h02;
	int n_mismatch = 0, checks = 0;
	gpab_ports gpab_ports_i (.*);
	gpab_pins gpab_pins_i (.a_out(port_a_pin_out), .a_oe(port_a_pin_oe), .b_out(port_b_pin_out),
		.b_oe(port_b_pin_oe), .a_board(8'h3C), .b_board(8'hC0), .a_in(port_a_pin_in),
		.b_in(port_b_pin_in));
	initial forever #12.5 clk = ~clk;
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{avs_address, avs_write, avs_read, avs_writedata} <= {a, w, !w, 24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		r = avs_response;
		{avs_write, avs_read} <= 2'b00;
		if (n >= 20) begin
			n_mismatch++;
			$display("BAD waitrequest expected 0 seen %b", avs_waitrequest);
		end
	endtask : bus
	task automatic rd(input logic [5:0] a, input logic [7:0] e, input string s);
		bus(1'b0, a, 8'h00);
		chk(s, e, q[7:0]);
	endtask : rd
	task automatic settle;
		repeat (3) @(posedge clk);
	endtask : settle
	task automatic results;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	initial begin
		#100000;
		n_mismatch++;
		$display("BAD watchdog expected done seen timeout");
		results();
	end
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		rd(6'h10, 8'h00, "dir_a");
		rd(6'h14, 8'h00, "dir_b");
		rd(6'h30, 8'h00, "led");
		rd(6'h08, 8'h00, "unmapped");
		chk("resp", 8'h02, {6'h0, r});
		bus(1'b1, 6'h00, 8'hA5);
		bus(1'b1, 6'h10, 8'h0F);
		bus(1'b1, 6'h30, 8'hFF);
		settle();
		rd(6'h00, 8'h35, "latch_a");
		rd(6'h30, 8'hFF, "led");
		chk("oe_a", 8'h0F, port_a_pin_oe);
		chk("out_a", 8'hA5, port_a_pin_out);
		chk("led_drive", 8'h0F, port_a_led_drive);
		converter_enable <= 1'b1;
		settle();
		chk("oe_conv", 8'h0B, port_a_pin_oe);
		converter_channel_select <= 5'h08;
		settle();
		chk("analog", 8'h00, port_a_analog_select);
		bus(1'b1, 6'h04, 8'h5A);
		bus(1'b1, 6'h14, 8'hFF);
		settle();
		chk("oe_b", 8'hF5, port_b_pin_oe);
		bus(1'b1, 6'h14, 8'h0F);
		rd(6'h04, 8'hCA, "latch_b");
		{i2c_module_enable, serial_interface_enable} <= 2'b11;
		{first_timer_ch0_select, second_timer_ch1_select} <= 4'h6;
		settle();
		chk("oe_periph", 8'h96, port_b_pin_oe);
		rd(6'h04, 8'hCA, "latch_b");
		{i2c_module_enable, serial_interface_enable, first_timer_ch0_select} <= 4'h0;
		second_timer_ch1_select <= 2'h0;
		settle();
		chk("oe_gpio", 8'h05, port_b_pin_oe);
		nrst <= 1'b0;
		settle();
		nrst <= 1'b1;
		rd(6'h00, 8'h3C, "pins_a");
		bus(1'b1, 6'h10, 8'hFF);
		bus(1'b1, 6'h14, 8'hFF);
		rd(6'h00, 8'hA5, "latch_a");
		rd(6'h04, 8'h5A, "latch_b");
		results();
	end
endmodule : test_gpab_ports
